// File: rtl/u2_status_buffer.sv
// Overview of operation
// - Nine-bit mode stores received ninth bit, bit 2
// - Transmit-done flag sets as stop bit begins
// - Receive-done flag sets at stop-bit sample point
// - Flags clear only by software write
// - Buffer write transmits, read returns received character
`timescale 1ns/1ns
`include "u2_cfg.svh"

module u2_status_buffer #(
  parameter logic [15:0] BAUD_DIV_RST = `U2_BAUD_RST
) (
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic [`U2_ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [`U2_ADDR_W-1:0]  s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  input  wire logic                   rxd,
  output logic                        txd,
  output logic                        irq
);

  // Word decode: index to byte address
  function automatic logic hit(input logic [`U2_ADDR_W-1:0] addr, input logic [7:0] idx);
    hit = (addr[`U2_ADDR_W-1:2] == {2'b00, idx});
  endfunction

  logic                   aw_hold_reg;
  logic [`U2_ADDR_W-1:0]  awaddr_reg;
  logic                   w_hold_reg;
  logic [31:0]            wdata_reg;
  logic [3:0]             wstrb_reg;
  logic                   bvalid_reg;
  logic [1:0]             bresp_reg;
  logic                   rvalid_reg;
  logic [31:0]            rdata_reg;
  logic [1:0]             rresp_reg;
  logic                   do_wr;
  logic                   wr_ctrl;
  logic                   wr_buf;
  logic                   wr_baud;
  logic                   wr_istat;
  logic                   wr_imask;
  logic                   wr_known;

  logic                   mode9_reg;
  logic                   rx_en_reg;
  logic                   tx_ninth_reg;
  logic                   rx_ninth_bit_reg;
  logic                   tx_done_flag_reg;
  logic                   rx_done_flag_reg;
  logic [7:0]             ctrl_rd;
  logic [15:0]            baud_div_reg;
  logic [1:0]             istat_reg;
  logic [1:0]             imask_reg;

  logic [7:0]             tx_data_reg;
  logic                   tx_pend_reg;
  u2_pkg::u2_phase_t      tx_phase_reg;
  logic [15:0]            tx_cnt_reg;
  logic [3:0]             tx_bit_reg;
  logic [8:0]             tx_shift_reg;
  logic                   txd_reg;
  logic                   tx_stop_set;
  logic                   tx_start;

  logic                   rx_sync1_reg;
  logic                   rx_sync2_reg;
  logic                   rx_prev_reg;
  u2_pkg::u2_phase_t      rx_phase_reg;
  logic [15:0]            rx_cnt_reg;
  logic [3:0]             rx_bit_reg;
  logic [8:0]             rx_shift_reg;
  logic [7:0]             rx_data_reg;
  logic                   rx_stop_set;
  logic [3:0]             frame_bits;

  // Bus handshakes; one write and one read in flight at most
  assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
  assign s_axi_wready  = !w_hold_reg && !bvalid_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;
  assign txd           = txd_reg;
  assign irq           = |(istat_reg & imask_reg);

  // Write address and data decode
  assign do_wr    = aw_hold_reg && w_hold_reg && !bvalid_reg;
  assign wr_ctrl  = do_wr && wstrb_reg[0] && hit(awaddr_reg, `U2_IDX_CTRL);
  assign wr_buf   = do_wr && wstrb_reg[0] && hit(awaddr_reg, `U2_IDX_BUF);
  assign wr_baud  = do_wr && hit(awaddr_reg, `U2_IDX_BAUD);
  assign wr_istat = do_wr && wstrb_reg[0] && hit(awaddr_reg, `U2_IDX_ISTAT);
  assign wr_imask = do_wr && wstrb_reg[0] && hit(awaddr_reg, `U2_IDX_IMASK);
  assign wr_known = hit(awaddr_reg, `U2_IDX_CTRL) || hit(awaddr_reg, `U2_IDX_BUF) ||
                    hit(awaddr_reg, `U2_IDX_BAUD) || hit(awaddr_reg, `U2_IDX_ISTAT) ||
                    hit(awaddr_reg, `U2_IDX_IMASK);
  assign frame_bits = mode9_reg ? (`U2_DATA_BITS + 4'h1) : `U2_DATA_BITS;

  // Control register read image; unused bits read zero
  always_comb begin
    ctrl_rd                  = 8'h00;
    ctrl_rd[`U2_CTRL_MODE]   = mode9_reg;
    ctrl_rd[`U2_CTRL_RXEN]   = rx_en_reg;
    ctrl_rd[`U2_CTRL_TX9]    = tx_ninth_reg;
    ctrl_rd[`U2_CTRL_RX9]    = rx_ninth_bit_reg;
    ctrl_rd[`U2_CTRL_TXDONE] = tx_done_flag_reg;
    ctrl_rd[`U2_CTRL_RXDONE] = rx_done_flag_reg;
  end

  // Write channels: address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg <= 1'b0;
      awaddr_reg  <= '0;
      w_hold_reg  <= 1'b0;
      wdata_reg   <= 32'h0000_0000;
      wstrb_reg   <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `U2_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_hold_reg <= 1'b0;
        w_hold_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= wr_known ? `U2_RESP_OKAY : `U2_RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // Read channel; reads have no side effects
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= `U2_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= `U2_RESP_OKAY;
      if (hit(s_axi_araddr, `U2_IDX_CTRL)) begin
        rdata_reg <= {24'h00_0000, ctrl_rd};
      end else if (hit(s_axi_araddr, `U2_IDX_BUF)) begin
        rdata_reg <= {24'h00_0000, rx_data_reg};
      end else if (hit(s_axi_araddr, `U2_IDX_BAUD)) begin
        rdata_reg <= {16'h0000, baud_div_reg};
      end else if (hit(s_axi_araddr, `U2_IDX_ISTAT)) begin
        rdata_reg <= {30'h0000_0000, istat_reg};
      end else if (hit(s_axi_araddr, `U2_IDX_IMASK)) begin
        rdata_reg <= {30'h0000_0000, imask_reg};
      end else begin
        rdata_reg <= 32'h0000_0000;
        rresp_reg <= `U2_RESP_SLVERR;
      end
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // Control fields; a hardware set beats a same-cycle software clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode9_reg        <= 1'b0;
      rx_en_reg        <= 1'b0;
      tx_ninth_reg     <= 1'b0;
      rx_ninth_bit_reg <= 1'b0;
      tx_done_flag_reg <= 1'b0;
      rx_done_flag_reg <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        mode9_reg        <= wdata_reg[`U2_CTRL_MODE];
        rx_en_reg        <= wdata_reg[`U2_CTRL_RXEN];
        tx_ninth_reg     <= wdata_reg[`U2_CTRL_TX9];
        rx_ninth_bit_reg <= wdata_reg[`U2_CTRL_RX9];
        tx_done_flag_reg <= wdata_reg[`U2_CTRL_TXDONE];
        rx_done_flag_reg <= wdata_reg[`U2_CTRL_RXDONE];
      end
      if (tx_stop_set) begin
        tx_done_flag_reg <= 1'b1;
      end
      if (rx_stop_set) begin
        rx_done_flag_reg <= 1'b1;
        if (mode9_reg) begin
          rx_ninth_bit_reg <= rx_shift_reg[8];
        end
      end
    end
  end

  // Bit period and interrupt registers; status is write-one-to-clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      baud_div_reg <= BAUD_DIV_RST;
      istat_reg    <= 2'h0;
      imask_reg    <= 2'h0;
    end else begin
      if (wr_baud && wstrb_reg[0]) begin
        baud_div_reg[7:0] <= wdata_reg[7:0];
      end
      if (wr_baud && wstrb_reg[1]) begin
        baud_div_reg[15:8] <= wdata_reg[15:8];
      end
      if (wr_imask) begin
        imask_reg <= wdata_reg[1:0];
      end
      istat_reg[`U2_IRQ_RX] <= rx_stop_set ||
        (istat_reg[`U2_IRQ_RX] && !(wr_istat && wdata_reg[`U2_IRQ_RX]));
      istat_reg[`U2_IRQ_TX] <= tx_stop_set ||
        (istat_reg[`U2_IRQ_TX] && !(wr_istat && wdata_reg[`U2_IRQ_TX]));
    end
  end

  // Transmit holding byte; separate from the receive byte
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_data_reg <= 8'h00;
      tx_pend_reg <= 1'b0;
    end else begin
      if (wr_buf) begin
        tx_data_reg <= wdata_reg[7:0];
        tx_pend_reg <= 1'b1;
      end else if (tx_start) begin
        tx_pend_reg <= 1'b0;
      end
    end
  end

  assign tx_start    = tx_pend_reg && (tx_phase_reg == u2_pkg::U2_IDLE) && !wr_buf;
  assign tx_stop_set = (tx_phase_reg == u2_pkg::U2_DATA) && (tx_cnt_reg == 16'h0000) &&
                       (tx_bit_reg == frame_bits - 4'h1);

  // Transmit shifter: start, data LSB first, optional ninth, stop
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_phase_reg <= u2_pkg::U2_IDLE;
      tx_cnt_reg   <= 16'h0000;
      tx_bit_reg   <= 4'h0;
      tx_shift_reg <= 9'h000;
      txd_reg      <= 1'b1;
    end else begin
      case (tx_phase_reg)
        u2_pkg::U2_IDLE: begin
          txd_reg <= 1'b1;
          if (tx_start) begin
            tx_shift_reg <= {tx_ninth_reg, tx_data_reg};
            tx_cnt_reg   <= baud_div_reg - 16'h0001;
            txd_reg      <= 1'b0;
            tx_phase_reg <= u2_pkg::U2_START;
          end
        end
        u2_pkg::U2_START: begin
          if (tx_cnt_reg == 16'h0000) begin
            tx_cnt_reg   <= baud_div_reg - 16'h0001;
            tx_bit_reg   <= 4'h0;
            txd_reg      <= tx_shift_reg[0];
            tx_shift_reg <= {1'b0, tx_shift_reg[8:1]};
            tx_phase_reg <= u2_pkg::U2_DATA;
          end else begin
            tx_cnt_reg <= tx_cnt_reg - 16'h0001;
          end
        end
        u2_pkg::U2_DATA: begin
          if (tx_cnt_reg == 16'h0000) begin
            tx_cnt_reg <= baud_div_reg - 16'h0001;
            if (tx_stop_set) begin
              txd_reg      <= 1'b1;
              tx_phase_reg <= u2_pkg::U2_STOP;
            end else begin
              tx_bit_reg   <= tx_bit_reg + 4'h1;
              txd_reg      <= tx_shift_reg[0];
              tx_shift_reg <= {1'b0, tx_shift_reg[8:1]};
            end
          end else begin
            tx_cnt_reg <= tx_cnt_reg - 16'h0001;
          end
        end
        u2_pkg::U2_STOP: begin
          if (tx_cnt_reg == 16'h0000) begin
            tx_phase_reg <= u2_pkg::U2_IDLE;
          end else begin
            tx_cnt_reg <= tx_cnt_reg - 16'h0001;
          end
        end
        default: begin
          tx_phase_reg <= u2_pkg::U2_IDLE;
        end
      endcase
    end
  end

  // Line input synchroniser; the second stage and its one-cycle-delayed copy feed logic
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_sync1_reg <= 1'b1;
      rx_sync2_reg <= 1'b1;
      rx_prev_reg  <= 1'b1;
    end else begin
      rx_sync1_reg <= rxd;
      rx_sync2_reg <= rx_sync1_reg;
      rx_prev_reg  <= rx_sync2_reg;
    end
  end

  assign rx_stop_set = (rx_phase_reg == u2_pkg::U2_STOP) && (rx_cnt_reg == 16'h0000);

  // Receive shifter: samples mid-bit; framing errors are not flagged
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_phase_reg <= u2_pkg::U2_IDLE;
      rx_cnt_reg   <= 16'h0000;
      rx_bit_reg   <= 4'h0;
      rx_shift_reg <= 9'h000;
      rx_data_reg  <= 8'h00;
    end else begin
      case (rx_phase_reg)
        u2_pkg::U2_IDLE: begin
          if (rx_en_reg && rx_prev_reg && !rx_sync2_reg) begin
            rx_cnt_reg   <= {1'b0, baud_div_reg[15:1]};
            rx_phase_reg <= u2_pkg::U2_START;
          end
        end
        u2_pkg::U2_START: begin
          if (rx_cnt_reg == 16'h0000) begin
            rx_cnt_reg   <= baud_div_reg - 16'h0001;
            rx_bit_reg   <= 4'h0;
            // Glitch rejection: a high line at mid start bit aborts
            rx_phase_reg <= rx_sync2_reg ? u2_pkg::U2_IDLE : u2_pkg::U2_DATA;
          end else begin
            rx_cnt_reg <= rx_cnt_reg - 16'h0001;
          end
        end
        u2_pkg::U2_DATA: begin
          if (rx_cnt_reg == 16'h0000) begin
            rx_cnt_reg   <= baud_div_reg - 16'h0001;
            rx_shift_reg <= {rx_sync2_reg, rx_shift_reg[8:1]};
            rx_bit_reg   <= rx_bit_reg + 4'h1;
            if (rx_bit_reg == frame_bits - 4'h1) begin
              rx_phase_reg <= u2_pkg::U2_STOP;
            end
          end else begin
            rx_cnt_reg <= rx_cnt_reg - 16'h0001;
          end
        end
        u2_pkg::U2_STOP: begin
          if (rx_stop_set) begin
            // Eight-bit frames sit one place higher in the shifter
            rx_data_reg  <= mode9_reg ? rx_shift_reg[7:0] : rx_shift_reg[8:1];
            rx_phase_reg <= u2_pkg::U2_IDLE;
          end else begin
            rx_cnt_reg <= rx_cnt_reg - 16'h0001;
          end
        end
        default: begin
          rx_phase_reg <= u2_pkg::U2_IDLE;
        end
      endcase
    end
  end

endmodule

// File: rtl/u2_cfg.svh
`ifndef U2_CFG_SVH
`define U2_CFG_SVH

// Register indices; byte address is four times the index
`define U2_IDX_CTRL      8'h8E
`define U2_IDX_BUF       8'h8F
`define U2_IDX_BAUD      8'h90
`define U2_IDX_ISTAT     8'h91
`define U2_IDX_IMASK     8'h92

// Control register field positions
`define U2_CTRL_MODE     7
`define U2_CTRL_RXEN     4
`define U2_CTRL_TX9      3
`define U2_CTRL_RX9      2
`define U2_CTRL_TXDONE   1
`define U2_CTRL_RXDONE   0

// Interrupt status and mask bit positions
`define U2_IRQ_RX        0
`define U2_IRQ_TX        1

// Bus, baud and frame constants
`define U2_ADDR_W        12
`define U2_RESP_OKAY     2'h0
`define U2_RESP_SLVERR   2'h2
`define U2_BAUD_RST      16'h0364
`define U2_DATA_BITS     4'h8

`endif

// File: rtl/u2_pkg.sv
package u2_pkg;

  // Shared serial frame phases for both shifters
  typedef enum logic [1:0] {
    U2_IDLE  = 2'b00,
    U2_START = 2'b01,
    U2_DATA  = 2'b10,
    U2_STOP  = 2'b11
  } u2_phase_t;

endpackage

// File: tb/u2_status_buffer_properties.sv
`timescale 1ns/1ns
module u2_props (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        txd,
  input wire logic        irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Both write channels taken at one edge
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_write_answer: assert property (s_wr_taken |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write response late or early");
  a_read_answer: assert property (s_rd_taken |=> s_axi_rvalid)
    else $error("read response missing");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
  a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted while answer pending");
  a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  // Flags only fall through a software write landing
  a_irq_cause: assert property ($fell(irq) |-> $rose(s_axi_bvalid))
    else $error("interrupt fell without a register write");
  a_tx_start: assert property ($fell(txd) |=> !txd [*3])
    else $error("start bit too short");
endmodule
bind u2_status_buffer u2_props chk_u (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .txd, .irq);

// File: tb/u2_line_peer.sv
`timescale 1ns/1ns
module u2_line_peer #(
  parameter int BIT = 8
) (
  input wire logic aclk,
  input wire logic txd,
  output logic     rxd
);
  logic [8:0] got_data;
  int         got_cnt;
  logic       nine;
  initial begin
    rxd = 1'b1;
    got_cnt = 0;
    nine = 1'b0;
  end
  // Send one frame, LSB first; line idles high like a real pull-up
  task send(input logic [8:0] d, input logic n);
    @(posedge aclk);
    rxd <= 1'b0;
    repeat (BIT) @(posedge aclk);
    for (int i = 0; i < (n ? 9 : 8); i++) begin
      rxd <= d[i];
      repeat (BIT) @(posedge aclk);
    end
    rxd <= 1'b1;
    repeat (BIT) @(posedge aclk);
  endtask
  // Sample mid-bit; stop level not judged here
  always begin
    @(negedge txd);
    repeat (BIT / 2) @(posedge aclk);
    got_data = 9'h000;
    for (int i = 0; i < (nine ? 9 : 8); i++) begin
      repeat (BIT) @(posedge aclk);
      got_data[i] = txd;
    end
    got_cnt++;
  end
endmodule

// File: tb/testbench.sv
`timescale 1ns/1ns
`include "u2_cfg.svh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_errors++; \
  $display("wrong value t=%0t got=%0h exp=%0h", $time, a, b); end end
module testbench;
  logic                  aclk, aresetn, rxd, txd, irq;
  logic                  s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic                  s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [`U2_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0]           s_axi_wdata, s_axi_rdata, q;
  logic [3:0]            s_axi_wstrb;
  logic [1:0]            s_axi_bresp, s_axi_rresp;
  logic [7:0]            d, e;
  logic                  n9, b8;
  int                    n_errors = 0, total_checks = 0, cyc = 0, g;

  u2_status_buffer dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .rxd, .txd, .irq);
  u2_line_peer #(.BIT(8)) peer_u (.aclk, .txd, .rxd);

  function logic [`U2_ADDR_W-1:0] ra(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction
  // Expected frame as the far side should see it
  function logic [8:0] frame_exp(input logic [7:0] b, input logic n, input logic nb);
    return {n & nb, b};
  endfunction

  task stop_test;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Handshakes judged at negedge so ready/valid are settled
  task wr(input logic [7:0] idx, input logic [31:0] v, input logic [1:0] er);
    logic ta, tw, tb;
    s_axi_awaddr <= ra(idx);
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b0;
    tb = 1'b0;
    // Response ready comes up at a random cycle and then stays, to stall the answer
    while (!tb) begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid && s_axi_bready;
      if (tb) `CHK(s_axi_bresp, er)
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (!s_axi_bready) s_axi_bready <= 1'($urandom);
    end
  endtask
  task rd(input logic [7:0] idx, input logic [1:0] er, output logic [31:0] r);
    logic ta, tv;
    s_axi_araddr <= ra(idx);
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b0;
    tv = 1'b0;
    // Read ready raised at a random cycle and then held until data is taken
    while (!tv) begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      tv = s_axi_rvalid && s_axi_rready;
      r = s_axi_rdata;
      if (tv) `CHK(s_axi_rresp, er)
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (!s_axi_rready) s_axi_rready <= 1'($urandom);
    end
  endtask
  task rc(input logic [7:0] idx, input logic [31:0] m, input logic [31:0] x);
    logic [31:0] r;
    rd(idx, `U2_RESP_OKAY, r);
    `CHK(r & m, x)
  endtask
  task irq_is(input logic x);
    @(negedge aclk);
    `CHK(irq, x)
    @(posedge aclk);
  endtask
  task send_tx(input logic [7:0] b);
    g = peer_u.got_cnt;
    wr(`U2_IDX_BUF, {24'h0000_00, b}, `U2_RESP_OKAY);
    while (peer_u.got_cnt == g) @(posedge aclk);
    repeat (8) @(posedge aclk);
  endtask

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // Hang guard
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      stop_test();
    end
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 4'h0;
    {s_axi_bready, s_axi_rready} = 2'b11;
    s_axi_awaddr = '0;
    s_axi_araddr = '0;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hf;
    q = $urandom(32'h3990_76f5);
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rc(`U2_IDX_CTRL, 32'hffff_ffff, 32'h0000_0000);
    rc(`U2_IDX_BAUD, 32'h0000_ffff, {16'h0000, `U2_BAUD_RST});
    // Write without byte lane 0 must leave the control byte alone
    s_axi_wstrb <= 4'he;
    wr(`U2_IDX_CTRL, 32'h0000_00ff, `U2_RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    rc(`U2_IDX_CTRL, 32'hffff_ffff, 32'h0000_0000);
    // Unmapped place: refused, reads zero
    wr(8'h00, 32'h0000_00ff, `U2_RESP_SLVERR);
    rd(8'h00, `U2_RESP_SLVERR, q);
    `CHK(q, 32'h0000_0000)
    wr(`U2_IDX_BAUD, 32'h0000_0008, `U2_RESP_OKAY);
    wr(`U2_IDX_IMASK, 32'h0000_0003, `U2_RESP_OKAY);
    // Both modes, both ninth-bit values, edge bytes first and last
    for (int k = 0; k < 4; k++) begin
      n9 = k[1];
      b8 = k[0];
      d = (k == 0) ? 8'h00 : (k == 3) ? 8'hff : 8'($urandom);
      e = 8'($urandom);
      peer_u.nine = n9;
      wr(`U2_IDX_CTRL, {24'h0000_00, n9, 2'b00, 1'b1, b8, 3'b000}, `U2_RESP_OKAY);
      send_tx(d);
      `CHK(peer_u.got_data, frame_exp(d, n9, b8))
      rc(`U2_IDX_CTRL, 32'h0000_0003, 32'h0000_0002);
      peer_u.send({~b8, e}, n9);
      rc(`U2_IDX_CTRL, 32'h0000_0007, {29'h0, n9 & ~b8, 2'b11});
      rc(`U2_IDX_BUF, 32'h0000_00ff, {24'h0000_00, e});
      wr(`U2_IDX_CTRL, {24'h0000_00, n9, 2'b00, 1'b1, b8, 3'b000}, `U2_RESP_OKAY);
      rc(`U2_IDX_CTRL, 32'h0000_0003, 32'h0000_0000);
      wr(`U2_IDX_ISTAT, 32'h0000_0003, `U2_RESP_OKAY);
    end
    // Interrupt raised, masked, cleared; buffer paths stay apart
    peer_u.nine = 1'b0;
    wr(`U2_IDX_CTRL, 32'h0000_0010, `U2_RESP_OKAY);
    send_tx(~e);
    `CHK(peer_u.got_data, frame_exp(~e, 1'b0, 1'b0))
    rc(`U2_IDX_BUF, 32'h0000_00ff, {24'h0000_00, e});
    rc(`U2_IDX_ISTAT, 32'h0000_0003, 32'h0000_0002);
    irq_is(1'b1);
    wr(`U2_IDX_IMASK, 32'h0000_0000, `U2_RESP_OKAY);
    irq_is(1'b0);
    wr(`U2_IDX_IMASK, 32'h0000_0003, `U2_RESP_OKAY);
    irq_is(1'b1);
    wr(`U2_IDX_ISTAT, 32'h0000_0002, `U2_RESP_OKAY);
    rc(`U2_IDX_ISTAT, 32'h0000_0003, 32'h0000_0000);
    irq_is(1'b0);
    stop_test();
  end
endmodule
